// file: tcal_pkg.sv
// What this block does
// (RQ1) The low power offset is a 15-bit two's-complement value in bits 14:0, upper bits zero.
// (RQ2) The high speed channel offset has the same form and is applied to high speed samples.
// (RQ3) One offset step is a quarter of a result LSB, so the correction has two fraction bits.
// (RQ4) Offset codes 0x3FFF, 0x4000 and 0x7FFF mean +4095.75, -4096 and -0.25 LSB.
// (RQ5) Offset code 0 leaves the result alone and code 1 means +0.25 LSB.
// (RQ6) Gain is a 15-bit multiplier where 0x4000 is exactly one.
// (RQ7) Gain 0x7FFF is the largest multiplier, near two, and 0x0001 the smallest, near 0.000061.
// (RQ8) Each gain code step changes the multiplier by about 0.000061.
// (RQ9) Gain 0x2000 halves the result.
// (RQ10) Software must not write gain zero; if it does, the result for that channel is zero.
// (RQ11) The high speed gain is used only for high speed samples.
// (RQ12) The low power gain is used only for low power samples.
// (RQ13) Reset loads each gain with 0x00004000 and each offset with zero.
// (RQ14) Calibration writes land only after the unlock key is written to the lock register.
// (RQ15) The offset is subtracted first, then the gain applied; the result saturates to 16 bits.
package tcal_pkg;

    // ------------------------------------------------------------
    // Register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] TCAL_LOCK_ADDR    = 32'h0000_2230;
    localparam logic [31:0] TCAL_HS_OFS_ADDR  = 32'h0000_2234;
    localparam logic [31:0] TCAL_HS_GAIN_ADDR = 32'h0000_2284;
    localparam logic [31:0] TCAL_LP_OFS_ADDR  = 32'h0000_2288;
    localparam logic [31:0] TCAL_LP_GAIN_ADDR = 32'h0000_228C;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int          TCAL_CAL_W      = 15;
    localparam int          TCAL_RES_W      = 16;
    localparam logic [14:0] TCAL_GAIN_RST   = 15'h4000;
    localparam logic [14:0] TCAL_OFS_RST    = 15'h0000;
    localparam logic [31:0] TCAL_UNLOCK_KEY = 32'hDE87_A5AF;
    localparam logic [31:0] TCAL_UNLOCKED_RD = 32'h0000_0001;
    localparam logic [31:0] TCAL_LOCKED_RD  = 32'h0000_0000;

    // Two quarter-LSB fraction bits plus fourteen gain fraction bits
    localparam int          TCAL_OFS_FRAC   = 2;
    localparam int          TCAL_GAIN_FRAC  = 14;
    localparam int          TCAL_SHIFT      = TCAL_OFS_FRAC + TCAL_GAIN_FRAC;

    localparam logic [15:0] TCAL_RES_MAX    = 16'hFFFF;
    localparam logic [15:0] TCAL_RES_MIN    = 16'h0000;

    // ------------------------------------------------------------
    // AHB-Lite encodings
    // ------------------------------------------------------------
    localparam logic [1:0]  TCAL_HTRANS_NSEQ = 2'h2;
    localparam logic        TCAL_HRESP_OKAY  = 1'b0;

    // ------------------------------------------------------------
    // Bus slave states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        TCAL_BUS_IDLE = 3'b001,
        TCAL_BUS_WAIT = 3'b010,
        TCAL_BUS_RESP = 3'b100
    } tcal_bus_state_t;

    // ------------------------------------------------------------
    // Sample carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        hs_sel;
        logic [15:0] data;
    } tcal_sample_t;

endpackage

// file: tcal_channel_cal.sv
// Decided for this implementation: the AHB-Lite slave port.
module tcal_channel_cal #(
    parameter int RAW_W = 16,
    parameter int CAL_W = 15
) (
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic      [31:0]           hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic                       cal_unlocked,
    input  wire tcal_pkg::tcal_sample_t raw_sample,
    output tcal_pkg::tcal_sample_t     cal_sample
);
    import tcal_pkg::*;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CAL_MSB = TCAL_CAL_W - 1;
    localparam int RSV_W   = 32 - TCAL_CAL_W;
    localparam int SEXT_W  = TCAL_RES_W + TCAL_OFS_FRAC + 1 - TCAL_CAL_W;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (RAW_W != TCAL_RES_W)
    begin : g_raw_chk
        $error("tcal_channel_cal: RAW_W must match the sample carrier");
    end
    if (CAL_W != TCAL_CAL_W)
    begin : g_cal_chk
        $error("tcal_channel_cal: CAL_W must match the register field");
    end
    if (SEXT_W < 1)
    begin : g_ext_chk
        $error("tcal_channel_cal: offset field wider than the scaled result");
    end

    // ------------------------------------------------------------
    // Shared arithmetic
    // ------------------------------------------------------------

    // Offset field sign-extended; code is quarter LSB units
    function automatic logic signed [18:0] ofs_ext(input logic [14:0] code);
        ofs_ext = {{SEXT_W{code[CAL_MSB]}}, code};    // RQ3
    endfunction

    // Word read back for a calibration field, reserved bits as zero
    function automatic logic [31:0] field_rd(input logic [14:0] v);
        field_rd = {{RSV_W{1'b0}}, v};    // RQ1
    endfunction

    // ------------------------------------------------------------
    // Bus address phase capture
    // ------------------------------------------------------------
    tcal_bus_state_t bus_q;
    logic [31:0]     addr_q;
    logic            wr_q;
    logic            accept;

    // Size is not decoded: every transfer is served as a whole word
    assign accept = hsel && hready && (htrans == TCAL_HTRANS_NSEQ);

    // One wait state per transfer so a read always sees earlier writes
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            bus_q <= TCAL_BUS_IDLE;
        end
        else
        begin
            case (bus_q)
                TCAL_BUS_IDLE:
                begin
                    if (accept)
                    begin
                        bus_q <= TCAL_BUS_WAIT;
                    end
                end
                TCAL_BUS_WAIT:
                begin
                    bus_q <= TCAL_BUS_RESP;
                end
                TCAL_BUS_RESP:
                begin
                    if (accept)
                    begin
                        bus_q <= TCAL_BUS_WAIT;
                    end
                    else
                    begin
                        bus_q <= TCAL_BUS_IDLE;
                    end
                end
                default:
                begin
                    bus_q <= TCAL_BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            addr_q <= 32'h0000_0000;
            wr_q   <= 1'b0;
        end
        else if (accept)
        begin
            addr_q <= haddr;
            wr_q   <= hwrite;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hreadyout <= 1'b1;
        end
        else if (bus_q == TCAL_BUS_WAIT)
        begin
            hreadyout <= 1'b1;
        end
        else if (accept)
        begin
            hreadyout <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hresp <= TCAL_HRESP_OKAY;
        end
        else
        begin
            hresp <= TCAL_HRESP_OKAY;
        end
    end

    // ------------------------------------------------------------
    // Calibration lock
    // ------------------------------------------------------------
    logic wr_now;
    logic cal_wr_ok;

    assign wr_now    = (bus_q == TCAL_BUS_WAIT) && wr_q;
    assign cal_wr_ok = wr_now && cal_unlocked;    // RQ14

    // Any other value written to the lock word closes it again
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_unlocked <= 1'b0;
        end
        else if (wr_now && (addr_q == TCAL_LOCK_ADDR))
        begin
            cal_unlocked <= (hwdata == TCAL_UNLOCK_KEY);    // RQ14
        end
    end

    // ------------------------------------------------------------
    // Calibration registers
    // ------------------------------------------------------------
    logic [14:0] lp_tia_offset_cal_q;
    logic [14:0] lp_tia_gain_cal_q;
    logic [14:0] hs_tia_offset_cal_q;
    logic [14:0] hs_tia_gain_cal_q;
    logic        lp_ofs_we;
    logic        lp_gain_we;
    logic        hs_ofs_we;
    logic        hs_gain_we;

    // Locked writes fall away here and still end with an OKAY
    assign lp_ofs_we  = cal_wr_ok && (addr_q == TCAL_LP_OFS_ADDR);
    assign lp_gain_we = cal_wr_ok && (addr_q == TCAL_LP_GAIN_ADDR);
    assign hs_ofs_we  = cal_wr_ok && (addr_q == TCAL_HS_OFS_ADDR);
    assign hs_gain_we = cal_wr_ok && (addr_q == TCAL_HS_GAIN_ADDR);

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lp_tia_offset_cal_q <= TCAL_OFS_RST;    // RQ13
        end
        else if (lp_ofs_we)
        begin
            lp_tia_offset_cal_q <= hwdata[CAL_MSB:0];    // RQ1
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lp_tia_gain_cal_q <= TCAL_GAIN_RST;    // RQ13
        end
        else if (lp_gain_we)
        begin
            lp_tia_gain_cal_q <= hwdata[CAL_MSB:0];    // RQ6
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hs_tia_offset_cal_q <= TCAL_OFS_RST;    // RQ13
        end
        else if (hs_ofs_we)
        begin
            hs_tia_offset_cal_q <= hwdata[CAL_MSB:0];    // RQ2
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hs_tia_gain_cal_q <= TCAL_GAIN_RST;    // RQ13
        end
        else if (hs_gain_we)
        begin
            hs_tia_gain_cal_q <= hwdata[CAL_MSB:0];    // RQ6
        end
    end

    // ------------------------------------------------------------
    // Read data, loaded in the wait state after any write lands
    // ------------------------------------------------------------
    logic [31:0] rd_d;

    always_comb
    begin
        case (addr_q)
            TCAL_LOCK_ADDR:
            begin
                rd_d = cal_unlocked ? TCAL_UNLOCKED_RD : TCAL_LOCKED_RD;
            end
            TCAL_LP_OFS_ADDR:
            begin
                rd_d = field_rd(lp_tia_offset_cal_q);    // RQ1
            end
            TCAL_LP_GAIN_ADDR:
            begin
                rd_d = field_rd(lp_tia_gain_cal_q);
            end
            TCAL_HS_OFS_ADDR:
            begin
                rd_d = field_rd(hs_tia_offset_cal_q);
            end
            TCAL_HS_GAIN_ADDR:
            begin
                rd_d = field_rd(hs_tia_gain_cal_q);
            end
            default:
            begin
                rd_d = 32'h0000_0000;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            hrdata <= 32'h0000_0000;
        end
        else if ((bus_q == TCAL_BUS_WAIT) && !wr_q)
        begin
            hrdata <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // Correction datapath
    // ------------------------------------------------------------
    logic [14:0]        sel_ofs;
    logic [14:0]        sel_gain;
    logic signed [18:0] raw_q2;
    logic signed [19:0] diff;
    logic signed [35:0] prod;
    logic signed [35:0] scaled;
    logic [15:0]        sat_d;

    // Each channel's pair is used only for its own samples
    assign sel_ofs  = raw_sample.hs_sel ? hs_tia_offset_cal_q    // RQ2
                                        : lp_tia_offset_cal_q;   // RQ1
    assign sel_gain = raw_sample.hs_sel ? hs_tia_gain_cal_q      // RQ11
                                        : lp_tia_gain_cal_q;     // RQ12

    // Raw result scaled into quarter LSB units
    assign raw_q2 = signed'({1'b0, raw_sample.data, 2'b00});    // RQ3

    // Offset first; a negative code adds to the result
    assign diff = 20'(raw_q2) - 20'(ofs_ext(sel_ofs));    // RQ4 RQ5 RQ15

    // Gain is positive, 0x4000 is one, one code is 2^-14
    assign prod   = 36'(diff) * signed'(36'({1'b0, sel_gain}));    // RQ6 RQ7 RQ8 RQ9
    assign scaled = prod >>> TCAL_SHIFT;

    // Clamp to the unsigned result range; gain zero lands on zero
    always_comb
    begin
        if (scaled < 36'sd0)
        begin
            sat_d = TCAL_RES_MIN;    // RQ15
        end
        else if (scaled > signed'(36'({20'h0_0000, TCAL_RES_MAX})))
        begin
            sat_d = TCAL_RES_MAX;    // RQ15
        end
        else
        begin
            sat_d = scaled[TCAL_RES_W-1:0];    // RQ10
        end
    end

    // One cycle of latency; the truncation rounds toward minus infinity
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cal_sample <= '0;
        end
        else
        begin
            cal_sample.valid  <= raw_sample.valid;
            cal_sample.hs_sel <= raw_sample.hs_sel;
            cal_sample.data   <= raw_sample.valid ? sat_d : cal_sample.data;
        end
    end

endmodule

// file: tcal_cal_properties.sv
module tcal_cal_properties (
    input wire logic                   ref_clk,
    input wire logic                   rst_n,
    input wire logic                   hsel,
    input wire logic [31:0]            haddr,
    input wire logic [1:0]             htrans,
    input wire logic                   hwrite,
    input wire logic [31:0]            hwdata,
    input wire logic                   hready,
    input wire logic [31:0]            hrdata,
    input wire logic                   hreadyout,
    input wire logic                   hresp,
    input wire logic                   cal_unlocked,
    input wire tcal_pkg::tcal_sample_t raw_sample,
    input wire tcal_pkg::tcal_sample_t cal_sample
);
    timeunit 1ns;
    timeprecision 1ps;
    import tcal_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    // ----
    // Bus steps
    // ----
    sequence s_taken;
        hsel && hready && htrans == TCAL_HTRANS_NSEQ;
    endsequence
    sequence s_lock_wr;
        s_taken ##0 (hwrite && haddr == TCAL_LOCK_ADDR);
    endsequence
    sequence s_read;
        s_taken ##0 !hwrite;
    endsequence

    chk_one_wait: assert property (s_taken |=> !hreadyout ##1 hreadyout)
        else $error("transfer without exactly one wait state");
    chk_resp_okay: assert property (hresp == TCAL_HRESP_OKAY)
        else $error("bus response not okay");
    chk_key_unlock: assert property (
        s_lock_wr ##1 (hwdata == TCAL_UNLOCK_KEY) |=> cal_unlocked)
        else $error("unlock key did not unlock");
    chk_other_relock: assert property (
        s_lock_wr ##1 (hwdata != TCAL_UNLOCK_KEY) |=> !cal_unlocked)
        else $error("wrong key left block unlocked");
    chk_unlock_cause: assert property (
        $rose(cal_unlocked) |-> $past(hwdata) == TCAL_UNLOCK_KEY)
        else $error("unlocked without the key");
    chk_lock_read: assert property (
        s_read ##0 (haddr == TCAL_LOCK_ADDR) |->
        ##2 hrdata == (cal_unlocked ? TCAL_UNLOCKED_RD : TCAL_LOCKED_RD))
        else $error("lock status read wrong");
    chk_reserved_zero: assert property (
        s_read |-> ##2 hrdata[31:15] == 17'h0)
        else $error("reserved read bits not zero");
    chk_sample_delay: assert property (
        raw_sample.valid |=> cal_sample.valid && cal_sample.hs_sel == $past(raw_sample.hs_sel))
        else $error("sample strobe or channel not carried");
    chk_data_hold: assert property (
        !raw_sample.valid |=> $stable(cal_sample.data))
        else $error("result changed without a sample");
endmodule

bind tcal_channel_cal tcal_cal_properties u_props (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .cal_unlocked(cal_unlocked),
    .raw_sample(raw_sample), .cal_sample(cal_sample)
);

// file: tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import tcal_pkg::*;

    logic ref_clk, rst_n, hsel, hwrite, hresp, cal_unlocked, hreadyout;
    logic [31:0] haddr, hwdata, hrdata, r;
    logic [1:0] htrans;
    logic [2:0] hsize;
    wire logic hready = hreadyout;
    tcal_sample_t raw_sample, cal_sample;
    int mismatches, n_compared;
    logic [14:0] ofs_t [7] = '{15'h3FFF, 15'h4000, 15'h7FFF, 15'h0000,
                               15'h0001, 15'h0000, 15'h3FFF};
    logic [14:0] gn_t [7]  = '{15'h4000, 15'h7FFF, 15'h0001, 15'h4001,
                               15'h3FFF, 15'h2000, 15'h0000};
    logic [15:0] raw_t [7] = '{16'h0100, 16'hFFFF, 16'h0001, 16'h1234,
                               16'h0010, 16'hF000, 16'h4000};

    tcal_channel_cal DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .cal_unlocked(cal_unlocked),
        .raw_sample(raw_sample), .cal_sample(cal_sample)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // ----
    // Tasks
    // ----
    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Master holds each phase until hready is seen high; bounded wait
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= TCAL_HTRANS_NSEQ;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (hready !== 1'b1 && n < 50);
        htrans <= 2'h0;
        hwdata <= d;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (hready !== 1'b1 && n < 50);
        r = hrdata;
        if (n >= 50)
        begin
            mismatches++;
            conclude();
        end
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        check(r, exp);
    endtask

    function automatic logic [31:0] model(logic [15:0] d, logic [14:0] o, logic [14:0] g);
        longint v;
        v = ((longint'(d) * 4 - longint'($signed(o))) * longint'(g)) >>> TCAL_SHIFT;
        if (v < 0) v = 0;
        if (v > 65535) v = 65535;
        return 32'(v);
    endfunction

    // High speed then low power sample back to back
    task automatic pair(input logic [15:0] dh, dl, input logic [31:0] eh, el);
        raw_sample <= '{1'b1, 1'b1, dh};
        @(posedge ref_clk);
        raw_sample <= '{1'b1, 1'b0, dl};
        #1 check({14'h0, cal_sample}, {14'h0, 2'b11, eh[15:0]});
        @(posedge ref_clk);
        raw_sample <= '0;
        #1 check({14'h0, cal_sample}, {14'h0, 2'b10, el[15:0]});
        @(posedge ref_clk);
    endtask

    // ----
    // Sequence
    // ----
    initial
    begin
        {rst_n, hsel, hwrite, haddr, hwdata, htrans, raw_sample} <= '0;
        hsize <= 3'h2;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        rd(TCAL_HS_OFS_ADDR, 32'h0000_0000);
        rd(TCAL_HS_GAIN_ADDR, 32'h0000_4000);
        rd(TCAL_LP_OFS_ADDR, 32'h0000_0000);
        rd(TCAL_LP_GAIN_ADDR, 32'h0000_4000);
        rd(TCAL_LOCK_ADDR, TCAL_LOCKED_RD);
        pair(16'h1234, 16'hABCD, 32'h1234, 32'hABCD);
        xfer(1'b1, TCAL_HS_GAIN_ADDR, 32'h0000_2000);
        rd(TCAL_HS_GAIN_ADDR, 32'h0000_4000);
        xfer(1'b1, TCAL_LOCK_ADDR, TCAL_UNLOCK_KEY);
        rd(TCAL_LOCK_ADDR, TCAL_UNLOCKED_RD);
        check(32'(cal_unlocked), 32'h0000_0001);
        for (int i = 0; i < 7; i++)
        begin
            xfer(1'b1, TCAL_HS_OFS_ADDR, 32'hFFFF_8000 | 32'(ofs_t[i]));
            xfer(1'b1, TCAL_HS_GAIN_ADDR, 32'hFFFF_8000 | 32'(gn_t[i]));
            xfer(1'b1, TCAL_LP_OFS_ADDR, 32'(ofs_t[6-i]));
            xfer(1'b1, TCAL_LP_GAIN_ADDR, 32'(gn_t[6-i]));
            rd(TCAL_HS_OFS_ADDR, 32'(ofs_t[i]));
            rd(TCAL_HS_GAIN_ADDR, 32'(gn_t[i]));
            pair(raw_t[i], raw_t[6-i], model(raw_t[i], ofs_t[i], gn_t[i]),
                 model(raw_t[6-i], ofs_t[6-i], gn_t[6-i]));
        end
        xfer(1'b1, TCAL_LOCK_ADDR, 32'h0000_0001);
        rd(TCAL_LOCK_ADDR, TCAL_LOCKED_RD);
        check(32'(cal_unlocked), 32'h0000_0000);
        xfer(1'b1, TCAL_LP_GAIN_ADDR, 32'h0000_1111);
        rd(TCAL_LP_GAIN_ADDR, 32'(gn_t[0]));
        xfer(1'b1, 32'h0000_2238, 32'hFFFF_FFFF);
        rd(32'h0000_2238, 32'h0000_0000);
        conclude();
    end
endmodule
